// [hdl/acq_dma.sv]
/*
  acquisition engine: apb registers, trigger selection, converter
  sequencing with channel sweep, sample packing and a bus-master
  write port that moves longwords to host memory.
  assumes an external converter answering start with one done pulse,
  and a bus arbiter giving gnt and a target giving ready.
*/
// Operation
// RL1: ready flag goes low after each conversion
// RL2: channel in low nibble, value above
// RL3: value is unsigned twelve-bit code
// RL4: only both dma modes enable bus master
// RL5: host loads byte count and start address
// RL6: count in bytes, up to 2^26
// RL7: every data phase moves one longword
// RL8: dma results pushed, bus drains them
// RL9: drop bus request when nothing is held
// RL10: keep block running until count done
// RL11: completion raises optional irq, pollable
// RL12: no sweep means one fixed channel
// RL13: sweep counts down to zero, repeats
// RL14: stop after requested conversions or stop
// RL15: stop kills trigger and both timers; software mode still converts after stop
// RL16: transferred sample count stays readable
// RL17: status bit one running, zero done
// RL18: pace from two cascaded 16-bit dividers
// RL19: six trigger and transfer mode combinations
// RL20: sweep channel decrements then reloads start
// RL21: earlier sample in lower half
`timescale 1ns/1ps
`default_nettype none

module acq_dma (
  // clock and reset
  input  wire logic              CLOCK_I,
  input  wire logic              NRST_I,
  // register bus
  input  wire acq_pkg::apb_req_s APB_I,
  output var  acq_pkg::apb_rsp_s APB_O,
  // converter
  output var  acq_pkg::adc_cmd_s ADC_O,
  input  wire acq_pkg::adc_res_s ADC_I,
  input  wire logic              EXT_TRIG_I,
  // bus master write port
  output var  acq_pkg::mst_req_s MST_O,
  input  wire acq_pkg::mst_rsp_s MST_I,
  // completion request
  output var  logic              IRQ_O
);
  import acq_pkg::*;

  typedef struct packed {
    acq_state_e         st;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [2:0]         mode;
    logic               sweep;
    logic [3:0]         start_ch;
    logic               irq_en;
    logic [15:0]        div1;
    logic [15:0]        div2;
    logic [BYTES_W-1:0] byte_count;
    logic [31:0]        base_addr;
    logic [15:0]        result;
    logic               ready_n;
    logic               conv_start;
    logic               conv_busy;
    logic [3:0]         chan;
    logic [SAMP_W-1:0]  conv_left;
    logic [15:0]        pack_lo;
    logic               pack_half;
    logic [31:0]        hold;
    logic               hold_valid;
    logic               mst_valid;
    logic [31:0]        mst_addr;
    logic [BYTES_W-1:0] bytes_left;
    logic [SAMP_W-1:0]  xfer_samples;
    logic               done;
    logic               overrun;
    logic               irq;
    logic               ext_d;
  } acq_s;

  acq_s s;
  acq_s next_s;

  logic tick;
  logic wr_acc;
  logic rd_acc;
  logic soft_trig;
  logic start_cmd;
  logic stop_cmd;
  logic bm_en;
  logic trig;
  logic conv_done;
  logic [15:0] word;

  // dma-capable mode decode, shared by the datapath and status
  function automatic logic is_dma(input logic [2:0] m);
    return (m == MODE_TMR_DMA) || (m == MODE_EXT_DMA); // RL4
  endfunction

  function automatic logic is_timer(input logic [2:0] m);
    return (m == MODE_TMR_INT) || (m == MODE_TMR_DMA);
  endfunction

  // pacer only runs inside an acquisition in a timer mode
  pacer_timer u_pacer (
    .clk_i  (CLOCK_I),
    .nrst_i (NRST_I),
    .run_i  ((s.st == ST_RUN) && is_timer(s.mode)), // RL15 RL18
    .div1_i (s.div1),
    .div2_i (s.div2),
    .tick_o (tick)
  );

  // completed apb access phases; pready is high one cycle only
  assign wr_acc = APB_I.psel && APB_I.penable && s.pready &&
                  APB_I.pwrite;
  assign rd_acc = APB_I.psel && APB_I.penable && s.pready &&
                  !APB_I.pwrite;
  assign soft_trig = wr_acc && (APB_I.paddr == OFS_CMD) &&
                     APB_I.pwdata[CMD_TRIG];
  assign start_cmd = wr_acc && (APB_I.paddr == OFS_CMD) &&
                     APB_I.pwdata[CMD_START];
  assign stop_cmd  = wr_acc && (APB_I.paddr == OFS_CMD) &&
                     APB_I.pwdata[CMD_STOP];
  assign bm_en     = is_dma(s.mode);
  assign conv_done = ADC_I.done && s.conv_busy;
  assign word      = {ADC_I.data, s.chan}; // RL2 RL3

  // trigger source by mode; software mode converts outside a run
  always_comb begin
    trig = 1'b0;
    unique case (s.mode) // RL19
      MODE_SW_POLL: trig = soft_trig;
      MODE_TMR_INT, MODE_TMR_DMA: trig = tick;
      MODE_EXT_POLL, MODE_EXT_INT, MODE_EXT_DMA:
        trig = EXT_TRIG_I && !s.ext_d;
      default: trig = 1'b0;
    endcase
    if (s.conv_busy) begin // one conversion at a time
      trig = 1'b0;
    end
    if (s.mode != MODE_SW_POLL) begin // RL15
      trig = trig && (s.st == ST_RUN) && (s.conv_left != '0); // RL14
    end
  end

  // whole next state
  always_comb begin
    next_s = s;
    next_s.conv_start = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.ext_d = EXT_TRIG_I;

    // apb setup phase: capture read data, answer next cycle
    if (APB_I.psel && !APB_I.penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = '0;
      unique case (APB_I.paddr)
        OFS_CTRL: next_s.prdata = {23'h0, s.irq_en, s.start_ch,
                                   s.sweep, s.mode};
        OFS_CMD: next_s.prdata = '0;
        OFS_DIV1: next_s.prdata = {16'h0, s.div1};
        OFS_DIV2: next_s.prdata = {16'h0, s.div2};
        OFS_RESULT: next_s.prdata = {16'h0, s.result};
        OFS_COUNT: next_s.prdata = {5'h0, s.byte_count};
        OFS_ADDR: next_s.prdata = s.base_addr;
        OFS_STATUS: next_s.prdata = {27'h0, s.overrun, bm_en,
                                     s.done, s.st == ST_RUN, // RL17
                                     s.ready_n}; // RL1 RL11
        OFS_XFER: next_s.prdata = {6'h0, s.xfer_samples}; // RL16
        default: next_s.pslverr = 1'b1;
      endcase
    end

    // register writes at the access edge
    if (wr_acc) begin
      unique case (APB_I.paddr)
        OFS_CTRL: begin
          next_s.mode = APB_I.pwdata[CTRL_MODE_LSB +: 3];
          next_s.sweep = APB_I.pwdata[CTRL_SWEEP];
          next_s.start_ch = APB_I.pwdata[CTRL_CH_LSB +: 4];
          next_s.irq_en = APB_I.pwdata[CTRL_IRQ_EN];
          // idle converter follows a new channel at once, else
          // polled conversions would use the channel left from reset
          if ((s.st == ST_IDLE) && !s.conv_busy) begin
            next_s.chan = APB_I.pwdata[CTRL_CH_LSB +: 4]; // RL12
          end
        end
        OFS_DIV1: next_s.div1 = APB_I.pwdata[15:0]; // RL18
        OFS_DIV2: next_s.div2 = APB_I.pwdata[15:0]; // RL18
        OFS_COUNT: next_s.byte_count = APB_I.pwdata[BYTES_W-1:0]; // RL6
        OFS_ADDR: next_s.base_addr = APB_I.pwdata; // RL5
        default: ;
      endcase
    end

    // reading the result rearms the flag; a new result wins below
    if (rd_acc && (APB_I.paddr == OFS_RESULT)) begin
      next_s.ready_n = 1'b1;
    end

    // start: count and address are latched here
    if (start_cmd && (s.st == ST_IDLE)) begin
      next_s.done = 1'b0;
      next_s.overrun = 1'b0;
      next_s.chan = s.start_ch;
      next_s.conv_left = s.byte_count[BYTES_W-1:1]; // RL14
      next_s.bytes_left = s.byte_count; // RL6
      next_s.mst_addr = s.base_addr; // RL5
      next_s.xfer_samples = '0;
      next_s.pack_half = 1'b0;
      if (s.byte_count == '0) begin
        next_s.done = 1'b1;
      end else begin
        next_s.st = ST_RUN;
      end
    end

    // stop: no further timer or external triggers; counters stay readable
    if (stop_cmd && (s.st == ST_RUN)) begin
      next_s.st = ST_IDLE; // RL15 RL16
      if (!s.mst_valid) begin
        next_s.hold_valid = 1'b0;
      end
    end

    // issue a conversion
    if (trig) begin
      next_s.conv_start = 1'b1;
      next_s.conv_busy = 1'b1;
    end

    // bus-master data phase ends on ready
    if (s.mst_valid && MST_I.ready) begin
      next_s.mst_valid = 1'b0;
      next_s.hold_valid = 1'b0; // RL8 RL9
      next_s.mst_addr = s.mst_addr + LW_STEP; // RL7
      next_s.xfer_samples = s.xfer_samples + 26'h2; // RL7
      if (s.bytes_left <= LW_BYTES) begin
        next_s.bytes_left = '0;
        if (s.st == ST_RUN) begin // RL10
          next_s.st = ST_IDLE;
          next_s.done = 1'b1; // RL11
        end
      end else begin
        next_s.bytes_left = s.bytes_left - LW_BYTES; // RL10
      end
    end else if (s.hold_valid && !s.mst_valid && MST_I.gnt) begin
      next_s.mst_valid = 1'b1;
    end

    // conversion result
    if (conv_done) begin
      next_s.conv_busy = 1'b0;
      next_s.result = word; // RL2
      next_s.ready_n = 1'b0; // RL1
      if (!s.sweep) begin
        next_s.chan = s.start_ch; // RL12
      end else if (s.chan == 4'h0) begin
        next_s.chan = s.start_ch; // RL13 RL20
      end else begin
        next_s.chan = s.chan - 4'h1; // RL13 RL20
      end
      if (s.st == ST_RUN) begin
        next_s.conv_left = s.conv_left - 26'h1; // RL14
        if (!bm_en && (s.conv_left == 26'h1)) begin
          next_s.st = ST_IDLE; // RL14
          next_s.done = 1'b1;
        end
      end
      // pack two samples per longword, earliest low
      if (bm_en && (s.st == ST_RUN)) begin // RL8
        if (s.pack_half || (s.conv_left == 26'h1)) begin
          next_s.pack_half = 1'b0;
          if (next_s.hold_valid) begin
            next_s.overrun = 1'b1; // bus too slow, sample lost
          end else begin
            next_s.hold_valid = 1'b1; // RL9
            next_s.hold = s.pack_half ? {word, s.pack_lo} // RL21
                                      : {16'h0, word};
          end
        end else begin
          next_s.pack_lo = word; // RL21
          next_s.pack_half = 1'b1;
        end
      end
    end

    next_s.irq = next_s.done && next_s.irq_en; // RL11
  end

  // all state in one register
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.ready_n <= 1'b1;
      s.div1 <= DIV_RST;
      s.div2 <= DIV_RST;
      s.result <= RESULT_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign APB_O = '{prdata: s.prdata, pready: s.pready,
                   pslverr: s.pslverr};
  assign ADC_O = '{start: s.conv_start, channel: s.chan};
  assign MST_O = '{req: s.hold_valid, valid: s.mst_valid, // RL9
                   addr: s.mst_addr, data: s.hold};
  assign IRQ_O = s.irq;

  // checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);

  property p_ready_low;
    conv_done |=> !s.ready_n;
  endproperty
  a_ready_low: assert property (p_ready_low) // RL1
    else $error("ready flag not low after conversion");

  property p_word_layout;
    conv_done |=> (s.result[3:0] == $past(s.chan)) &&
                  (s.result[15:4] == $past(ADC_I.data));
  endproperty
  a_word_layout: assert property (p_word_layout) // RL2
    else $error("result word layout wrong");

  property p_req_dma_only;
    $rose(s.hold_valid) |-> is_dma($past(s.mode));
  endproperty
  a_req_dma_only: assert property (p_req_dma_only) // RL4
    else $error("bus request outside dma mode");

  property p_lw_step;
    s.mst_valid && MST_I.ready |=>
      (s.mst_addr == $past(s.mst_addr) + LW_STEP) && !s.mst_valid;
  endproperty
  a_lw_step: assert property (p_lw_step) // RL7
    else $error("address did not advance one longword");

  property p_release;
    s.mst_valid && MST_I.ready && !conv_done |=> !MST_O.req;
  endproperty
  a_release: assert property (p_release) // RL9
    else $error("bus request held with nothing to send");

  property p_no_early_end;
    (s.st == ST_RUN) && bm_en && (s.bytes_left > LW_BYTES) &&
      !stop_cmd |=> (s.st == ST_RUN) && !s.done;
  endproperty
  a_no_early_end: assert property (p_no_early_end) // RL10
    else $error("block ended before byte count");

  property p_fixed_chan;
    conv_done && !s.sweep |=> s.chan == $past(s.start_ch);
  endproperty
  a_fixed_chan: assert property (p_fixed_chan) // RL12
    else $error("channel moved with sweep off");

  property p_sweep_step;
    conv_done && s.sweep && (s.chan != 4'h0) |=>
      s.chan == $past(s.chan) - 4'h1;
  endproperty
  a_sweep_step: assert property (p_sweep_step) // RL20
    else $error("sweep did not decrement");

  property p_stop_quiet;
    stop_cmd && (s.st == ST_RUN) |=> (s.st == ST_IDLE) ##1 !tick[*4];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) // RL15
    else $error("pacer still ticking after stop");

endmodule // acq_dma

`default_nettype wire

// [hdl/pacer_timer.sv]
/*
  pacer timer: two cascaded 16-bit down-count dividers that give one
  tick every div1 * div2 clocks while run is high.
  assumes dividers stay steady while running; zero counts as one.
*/
`timescale 1ns/1ps
`default_nettype none

module pacer_timer (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // control
  input  wire logic        run_i,
  input  wire logic [15:0] div1_i,
  input  wire logic [15:0] div2_i,
  // pacing tick
  output var  logic        tick_o
);
  import acq_pkg::*;

  typedef struct packed {
    logic [15:0] cnt1;
    logic [15:0] cnt2;
    logic        tick;
  } pacer_s;

  pacer_s s;
  pacer_s next_s;

  // cascade: first stage wraps, second stage steps on each wrap
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run_i) begin // halted, reload both stages
      next_s.cnt1 = div1_i;
      next_s.cnt2 = div2_i;
    end else if (s.cnt1 <= 16'h0001) begin
      next_s.cnt1 = div1_i;
      if (s.cnt2 <= 16'h0001) begin
        next_s.cnt2 = div2_i;
        next_s.tick = 1'b1;
      end else begin
        next_s.cnt2 = s.cnt2 - 16'h0001;
      end
    end else begin
      next_s.cnt1 = s.cnt1 - 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '{cnt1: DIV_RST, cnt2: DIV_RST, tick: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;

endmodule // pacer_timer

`default_nettype wire

// [shared/acq_pkg.sv]
/*
  acquisition block package: register map, field positions, modes,
  state codes and the carrier structs of the top-level ports.
  assumes one clock domain and a 32-bit apb register bus.
*/
package acq_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_DIV1   = 8'h08;
  localparam logic [7:0] OFS_DIV2   = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_COUNT  = 8'h14;
  localparam logic [7:0] OFS_ADDR   = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_XFER   = 8'h20;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SWEEP    = 3;
  localparam int CTRL_CH_LSB   = 4;
  localparam int CTRL_IRQ_EN   = 8;

  // command register bits, write one to act
  localparam int CMD_TRIG  = 0;
  localparam int CMD_START = 1;
  localparam int CMD_STOP  = 2;

  // status register bits
  localparam int STS_READY_N = 0;
  localparam int STS_RUN     = 1;
  localparam int STS_DONE    = 2;
  localparam int STS_BM_EN   = 3;
  localparam int STS_OVERRUN = 4;

  // acquisition modes: trigger source and transfer kind
  localparam logic [2:0] MODE_SW_POLL  = 3'h0;
  localparam logic [2:0] MODE_TMR_INT  = 3'h1;
  localparam logic [2:0] MODE_TMR_DMA  = 3'h2;
  localparam logic [2:0] MODE_EXT_POLL = 3'h3;
  localparam logic [2:0] MODE_EXT_INT  = 3'h4;
  localparam logic [2:0] MODE_EXT_DMA  = 3'h5;

  // widths and sizes
  localparam int BYTES_W = 27;
  localparam int SAMP_W  = 26;
  localparam logic [26:0] LW_BYTES = 27'h4;
  localparam logic [31:0] LW_STEP  = 32'h4;

  // reset values
  localparam logic [15:0] DIV_RST    = 16'h0001;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // acquisition state, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } acq_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic        start;
    logic [3:0]  channel;
  } adc_cmd_s;

  typedef struct packed {
    logic        done;
    logic [11:0] data;
  } adc_res_s;

  typedef struct packed {
    logic        req;
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } mst_req_s;

  typedef struct packed {
    logic        gnt;
    logic        ready;
  } mst_rsp_s;

endpackage

// [tb/host_bus_model.sv]
/*
  host bus model: grants the bus master port and accepts each data
  phase, at once or after a few cycles while slow is set.
  assumes the engine holds req and valid until it sees ready.
*/
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  // answer pacing
  input  wire logic              slow_i,
  // engine side
  input  wire acq_pkg::mst_req_s mst_i,
  output var  acq_pkg::mst_rsp_s mst_o
);
  import acq_pkg::*;

  logic [2:0] wait_cnt;

  // grant after the wait runs out; ready is a one-cycle accept
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mst_o    <= '0;
      wait_cnt <= 3'h0;
    end else begin
      mst_o.ready <= 1'b0;
      if (!mst_i.req && !mst_i.valid) begin
        mst_o.gnt <= 1'b0;  // bus taken back once released
        wait_cnt  <= slow_i ? 3'h5 : 3'h0;
      end else if (wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
      end else begin
        mst_o.gnt   <= 1'b1;
        mst_o.ready <= mst_i.valid && !mst_o.ready;
      end
    end
  end
endmodule // host_bus_model
`default_nettype wire

// [tb/test_adc_bus_master_acquisition.sv]
/*
  testbench of the acquisition engine: apb tasks, converter model,
  external trigger, host bus model and a longword monitor.
  assumes the zero-wait apb slave and the package register map.
*/
`timescale 1ns/1ps
`default_nettype none

module test_adc_bus_master_acquisition;
  import acq_pkg::*;

  logic        CLOCK_I   = 1'b0;
  logic        NRST_I    = 1'b0;
  apb_req_s    apb_req   = '0;
  apb_rsp_s    apb_rsp;
  adc_cmd_s    adc_cmd;
  adc_res_s    adc_res   = '0;
  mst_req_s    mst_req;
  mst_rsp_s    mst_rsp;
  logic        ext_trig  = 1'b0;
  logic        irq;
  logic        slow      = 1'b0;
  logic        ext_en    = 1'b0;
  logic        force_max = 1'b0;
  logic        dma       = 1'b0;
  logic        sweep     = 1'b0;
  logic        dma_chk   = 1'b1;
  logic        half_v    = 1'b0;
  logic        err;
  logic [2:0]  cnv_wait  = 3'h0;
  logic [4:0]  ext_cnt   = 5'h0;
  logic [3:0]  exp_ch;
  logic [3:0]  start_ch;
  logic [11:0] smp;
  logic [15:0] half;
  logic [15:0] last_word;
  logic [31:0] rnd       = 32'h7c40;
  logic [31:0] exp_addr;
  logic [31:0] rdv;
  logic [63:0] mon_e;
  logic [63:0] exp_q[$];
  int          fail_count = 0;
  int          checked    = 0;
  int          cyc = 0, last_start = 0, gap = 0, n_start = 0, lw_cnt = 0;
  int          s0, s_lw;

  always #12.5 CLOCK_I = ~CLOCK_I;

  acq_dma u_acq_dma (.CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .APB_I(apb_req),
    .APB_O(apb_rsp), .ADC_O(adc_cmd), .ADC_I(adc_res),
    .EXT_TRIG_I(ext_trig), .MST_O(mst_req), .MST_I(mst_rsp), .IRQ_O(irq));

  host_bus_model u_host_bus_model (.clk_i(CLOCK_I), .nrst_i(NRST_I),
    .slow_i(slow), .mst_i(mst_req), .mst_o(mst_rsp));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge CLOCK_I);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge CLOCK_I);
    apb_req.penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge CLOCK_I);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r & m, e);
  endtask

  // poll a status bit with a bounded count of reads
  task automatic wait_bit(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0, rdv);
      n++;
    end while (rdv[b] !== v && n < 200);
    check({31'h0, rdv[b]}, {31'h0, v});
  endtask

  // converter model; notes each expected sample and packed longword
  always @(posedge CLOCK_I) begin
    cyc++;
    adc_res.done <= (cnv_wait == 3'h1);
    if (adc_cmd.start === 1'b1) begin
      gap = cyc - last_start;
      last_start = cyc;
      n_start++;
      cnv_wait <= 3'h2 + {1'b0, rnd[1:0]};
    end else if (cnv_wait != 3'h0) begin
      cnv_wait <= cnv_wait - 3'h1;
    end
    if (cnv_wait == 3'h1) begin
      rnd = lfsr(rnd);
      smp = force_max ? 12'hFFF : rnd[11:0];
      adc_res.data <= smp;
      slow <= rnd[5];
      last_word = {smp, exp_ch};
      if (sweep) exp_ch = (exp_ch == 4'h0) ? start_ch : exp_ch - 4'h1;
      if (dma && half_v) begin
        exp_q.push_back({exp_addr, last_word, half});
        exp_addr += 32'h4;
      end
      if (dma) half_v = !half_v;
      half = last_word;
    end else begin
      adc_res.data <= ~adc_res.data;  // no stale value between results
    end
  end

  // external trigger: a rising edge every 32 clocks when enabled
  always @(posedge CLOCK_I) begin
    ext_cnt <= ext_cnt + 5'h1;
    ext_trig <= ext_en && ext_cnt[4];
  end

  // longword monitor against the oldest note
  always @(posedge CLOCK_I) begin
    if (mst_req.valid === 1'b1 && mst_rsp.ready === 1'b1) begin
      lw_cnt++;
      if (dma_chk && exp_q.size() == 0) begin
        check(32'h1, 32'h0);
      end else if (dma_chk) begin
        mon_e = exp_q.pop_front();
        check(mst_req.addr, mon_e[63:32]);
        check(mst_req.data, mon_e[31:0]);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge CLOCK_I);
    fail_count++;
    wrap_up;
  end

  initial begin
    repeat (12) @(posedge CLOCK_I);
    NRST_I <= 1'b1;
    rd_chk(OFS_STATUS, 32'hFFFFFFFF, 32'h1);
    rd_chk(OFS_DIV1, 32'hFFFF, {16'h0, DIV_RST});
    apb(1'b0, 8'h40, 32'h0, rdv);
    check(rdv, 32'h0);
    check({31'h0, err}, 32'h1);
    for (int m = 0; m < 6; m++) begin
      wr(OFS_CTRL, 32'(m));
      rd_chk(OFS_STATUS, 32'h8, (m == 2 || m == 5) ? 32'h8 : 32'h0);
    end
    $display("test done: reset, map and modes");
    // polled software conversions on channel 5, full-scale first
    start_ch = 4'h5;
    exp_ch = 4'h5;
    wr(OFS_CTRL, 32'h50);
    for (int k = 0; k < 2; k++) begin
      force_max = (k == 0);
      wr(OFS_CMD, 32'h1 << CMD_TRIG);
      wait_bit(STS_READY_N, 1'b0);
      rd_chk(OFS_RESULT, 32'hFFFF, {16'h0, last_word});
      rd_chk(OFS_STATUS, 32'h1, 32'h1);
    end
    force_max = 1'b0;
    $display("test done: polled conversions");
    // external trigger, sweep from channel 2, twelve bytes
    sweep = 1'b1;
    dma = 1'b1;
    start_ch = 4'h2;
    exp_ch = 4'h2;
    exp_addr = 32'h0010_0000;
    wr(OFS_CTRL, 32'h12D);
    wr(OFS_COUNT, 32'hC);
    wr(OFS_ADDR, exp_addr);
    wr(OFS_CMD, 32'h1 << CMD_START);
    rd_chk(OFS_STATUS, 32'h6, 32'h2);
    ext_en = 1'b1;
    wait_bit(STS_DONE, 1'b1);
    ext_en = 1'b0;
    rd_chk(OFS_STATUS, 32'hE, 32'hC);
    rd_chk(OFS_XFER, 32'hFFFFFFFF, 32'h6);
    check({31'h0, irq}, 32'h1);
    check(exp_q.size(), 32'h0);
    $display("test done: triggered sweep transfer");
    // timer paced, fixed channel 7, eight bytes
    sweep = 1'b0;
    start_ch = 4'h7;
    exp_ch = 4'h7;
    exp_addr = 32'h0020_0000;
    wr(OFS_CTRL, 32'h72);
    wr(OFS_DIV1, 32'h4);
    wr(OFS_DIV2, 32'h5);
    wr(OFS_COUNT, 32'h8);
    wr(OFS_ADDR, exp_addr);
    wr(OFS_CMD, 32'h1 << CMD_START);
    wait_bit(STS_DONE, 1'b1);
    check(gap, 32'h14);
    check({31'h0, irq}, 32'h0);
    rd_chk(OFS_XFER, 32'hFFFFFFFF, 32'h4);
    $display("test done: timer paced transfer");
    // long block stopped by the host part way
    dma_chk = 1'b0;
    s_lw = lw_cnt;
    wr(OFS_COUNT, 32'h190);
    wr(OFS_CMD, 32'h1 << CMD_START);
    s0 = n_start;
    for (int n = 0; n < 400 && n_start < s0 + 5; n++) @(posedge CLOCK_I);
    wr(OFS_CMD, 32'h1 << CMD_STOP);
    repeat (40) @(posedge CLOCK_I);
    s0 = n_start;
    repeat (200) @(posedge CLOCK_I);
    check(n_start, s0);
    rd_chk(OFS_STATUS, 32'h2, 32'h0);
    rd_chk(OFS_XFER, 32'hFFFFFFFF, 32'((lw_cnt - s_lw) * 2));
    exp_q.delete();
    $display("test done: host stop");
    // external trigger, interrupt transfer: two conversions, no bus
    dma = 1'b0;
    start_ch = 4'h3;
    exp_ch = 4'h3;
    wr(OFS_CTRL, 32'h134);
    wr(OFS_COUNT, 32'h4);
    s0 = n_start;
    s_lw = lw_cnt;
    wr(OFS_CMD, 32'h1 << CMD_START);
    ext_en = 1'b1;
    wait_bit(STS_DONE, 1'b1);
    ext_en = 1'b0;
    check(n_start - s0, 32'h2);
    check(lw_cnt - s_lw, 32'h0);
    rd_chk(OFS_RESULT, 32'hF, 32'h3);
    check({31'h0, irq}, 32'h1);
    $display("test done: triggered interrupt mode");
    wrap_up;
  end
endmodule // test_adc_bus_master_acquisition
`default_nettype wire
